/* logic/ssd_map.svh */
// constants of the safety command decoder: command codes, offsets, resets
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH
// serial command codes
`define SSD_CMD_WD_TALLY_WR  8'ha4
`define SSD_CMD_PIN_TALLY_WR 8'ha7
`define SSD_CMD_DEV_TALLY_WR 8'ha8
`define SSD_CMD_STAT_TWO_RD  8'h52
`define SSD_CMD_STAT_THR_RD  8'h54
`define SSD_CMD_STAT_FOUR_RD 8'h57
`define SSD_CMD_HMAX_WR      8'h91
`define SSD_CMD_HMAX_RD      8'h61
`define SSD_CMD_HMIN_WR      8'h92
`define SSD_CMD_HMIN_RD      8'h62
`define SSD_CMD_LMAX_WR      8'h94
`define SSD_CMD_LMAX_RD      8'h64
`define SSD_CMD_LMIN_WR      8'h97
`define SSD_CMD_LMIN_RD      8'h67
`define SSD_CMD_PWD_WR       8'h98
`define SSD_CMD_PWD_RD       8'h68
`define SSD_CMD_CHK_WR       8'h9b
`define SSD_CMD_CHK_RD       8'h6b
`define SSD_CMD_LOCK_SET     8'h11
`define SSD_CMD_LOCK_CLR     8'h12
// serial frame
`define SSD_FRAME_BITS       5'h10
`define SSD_CMD_BITS         5'h08
// wishbone byte offsets
`define SSD_ADR_CTRL         8'h00
`define SSD_ADR_STAT         8'h04
`define SSD_ADR_IRQ_STAT     8'h08
`define SSD_ADR_IRQ_MASK     8'h0c
`define SSD_ADR_TALLY        8'h10
`define SSD_ADR_LIMITS       8'h14
`define SSD_ADR_CHECK        8'h18
// interrupt bit positions and width
`define SSD_IRQ_ACCEPT       0
`define SSD_IRQ_REFUSE       1
`define SSD_IRQ_LOCK         2
`define SSD_IRQ_ABORT        3
`define SSD_IRQ_W            4
// reset values and tally ceiling
`define SSD_RST_LOCK         1'h0
`define SSD_RST_DIAG         1'h0
`define SSD_RST_CFG          8'h00
`define SSD_RST_TALLY        4'h0
`define SSD_TALLY_MAX        4'hf
`endif

/* logic/ssd_pkg.sv */
// types and command decoding of the safety command decoder
`include "ssd_map.svh"
`default_nettype none
package ssd_pkg;
  typedef enum logic [3:0] {
    SSD_K_NONE,
    SSD_K_WD_WR,
    SSD_K_PIN_WR,
    SSD_K_DEV_WR,
    SSD_K_STAT_RD,
    SSD_K_CFG_WR,
    SSD_K_CFG_RD,
    SSD_K_LOCK_SET,
    SSD_K_LOCK_CLR
  } ssd_kind_type;

  function automatic ssd_kind_type ssd_classify(input logic [7:0] c);
    case (c)
      `SSD_CMD_WD_TALLY_WR:  return SSD_K_WD_WR;
      `SSD_CMD_PIN_TALLY_WR: return SSD_K_PIN_WR;
      `SSD_CMD_DEV_TALLY_WR: return SSD_K_DEV_WR;
      `SSD_CMD_STAT_TWO_RD, `SSD_CMD_STAT_THR_RD, `SSD_CMD_STAT_FOUR_RD:
        return SSD_K_STAT_RD;
      `SSD_CMD_HMAX_WR, `SSD_CMD_HMIN_WR, `SSD_CMD_LMAX_WR,
      `SSD_CMD_LMIN_WR, `SSD_CMD_PWD_WR, `SSD_CMD_CHK_WR:
        return SSD_K_CFG_WR;
      `SSD_CMD_HMAX_RD, `SSD_CMD_HMIN_RD, `SSD_CMD_LMAX_RD,
      `SSD_CMD_LMIN_RD, `SSD_CMD_PWD_RD, `SSD_CMD_CHK_RD:
        return SSD_K_CFG_RD;
      `SSD_CMD_LOCK_SET: return SSD_K_LOCK_SET;
      `SSD_CMD_LOCK_CLR: return SSD_K_LOCK_CLR;
      default: return SSD_K_NONE;
    endcase
  endfunction

  // slot 0..5: high max, high min, low max, low min, threshold, check value
  function automatic logic [2:0] ssd_cfg_index(input logic [7:0] c);
    case (c)
      `SSD_CMD_HMIN_WR, `SSD_CMD_HMIN_RD: return 3'h1;
      `SSD_CMD_LMAX_WR, `SSD_CMD_LMAX_RD: return 3'h2;
      `SSD_CMD_LMIN_WR, `SSD_CMD_LMIN_RD: return 3'h3;
      `SSD_CMD_PWD_WR,  `SSD_CMD_PWD_RD:  return 3'h4;
      `SSD_CMD_CHK_WR,  `SSD_CMD_CHK_RD:  return 3'h5;
      default: return 3'h0;
    endcase
  endfunction

  // tally slot of a status read or tally write: 0 watchdog, 1 pin, 2 device
  function automatic logic [1:0] ssd_tally_index(input logic [7:0] c);
    case (c)
      `SSD_CMD_PIN_TALLY_WR, `SSD_CMD_STAT_THR_RD:  return 2'h1;
      `SSD_CMD_DEV_TALLY_WR, `SSD_CMD_STAT_FOUR_RD: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction
endpackage
`default_nettype wire

/* logic/ssd_spi_link.sv */
// serial link slave: samples the link pins, frames command and data bytes
`include "ssd_map.svh"
`default_nettype none
module ssd_spi_link (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // link pins
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  output logic            miso_oe_o,
  // decoder side
  input  wire logic [7:0] status_i,
  input  wire logic [7:0] resp_i,
  output logic            cmd_valid_o,
  output logic            frame_valid_o,
  output logic            abort_o,
  output logic [15:0]     word_o
);
  logic [1:0]  sclk_s_q;
  logic [1:0]  cs_s_q;
  logic [1:0]  mosi_s_q;
  logic        sclk_prev_q;
  logic        cs_prev_q;
  logic [4:0]  cnt_q;
  logic [15:0] sh_q;
  logic [7:0]  tx_q;
  logic [7:0]  nxt_q;
  logic        cmd_valid_q;
  logic        frame_valid_q;
  logic        abort_q;
  logic        active;
  logic        rise;
  logic        fall;
  logic        cs_start;
  logic        cs_end;

  // two stages before anything looks at a pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_s_q <= 2'h0;
      cs_s_q   <= 2'h3;
      mosi_s_q <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk_i};
      cs_s_q   <= {cs_s_q[0], cs_n_i};
      mosi_s_q <= {mosi_s_q[0], mosi_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'h0;
      cs_prev_q   <= 1'h1;
    end else begin
      sclk_prev_q <= sclk_s_q[1];
      cs_prev_q   <= cs_s_q[1];
    end
  end

  assign active   = ~cs_s_q[1];
  assign rise     = active & sclk_s_q[1] & ~sclk_prev_q;
  assign fall     = active & ~sclk_s_q[1] & sclk_prev_q;
  assign cs_start = ~cs_s_q[1] & cs_prev_q;
  assign cs_end   = cs_s_q[1] & ~cs_prev_q;

  // bits past the sixteenth are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i || !active) begin
      cnt_q <= 5'h00;
    end else if (rise && cnt_q != `SSD_FRAME_BITS) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_q <= 16'h0000;
    end else if (rise && cnt_q != `SSD_FRAME_BITS) begin
      sh_q <= {sh_q[14:0], mosi_s_q[1]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_valid_q   <= 1'h0;
      frame_valid_q <= 1'h0;
      abort_q       <= 1'h0;
    end else begin
      cmd_valid_q   <= rise && cnt_q == `SSD_CMD_BITS - 5'h01;
      frame_valid_q <= rise && cnt_q == `SSD_FRAME_BITS - 5'h01;
      abort_q       <= cs_end && cnt_q != 5'h00 && cnt_q != `SSD_FRAME_BITS;
    end
  end

  // answer byte is swapped in at the falling edge after the command byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q  <= 8'h00;
      nxt_q <= 8'h00;
    end else begin
      if (cmd_valid_q) begin
        nxt_q <= resp_i;
      end
      if (cs_start) begin
        tx_q <= status_i;
      end else if (fall) begin
        tx_q <= (cnt_q == `SSD_CMD_BITS) ? nxt_q : {tx_q[6:0], 1'h0};
      end
    end
  end

  assign miso_o        = tx_q[7];
  assign miso_oe_o     = active;
  assign cmd_valid_o   = cmd_valid_q;
  assign frame_valid_o = frame_valid_q;
  assign abort_o       = abort_q;
  assign word_o        = sh_q;

  a_frame_after_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_valid_q |-> cnt_q == `SSD_FRAME_BITS)
    else $error("frame pulse without sixteen bits");
  a_abort_no_frame: assert property (@(posedge clk_i) disable iff (rst_i)
    abort_q |-> !frame_valid_q)
    else $error("aborted frame also completed");
endmodule
`default_nettype wire

/* logic/ssd_decoder.sv */
// safety status and configuration command decoder with wishbone registers
`include "ssd_map.svh"
`default_nettype none
module ssd_decoder
  import ssd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // serial link
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_o,
  // failure events from the monitors
  input  wire logic        wd_fail_event_i,
  input  wire logic        pin_fail_event_i,
  input  wire logic        dev_err_event_i,
  // interrupt
  output logic             irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic                  cmd_valid;
  logic                  frame_valid;
  logic                  frame_abort;
  logic [15:0]           word;
  logic [7:0]            resp;
  logic [7:0]            status_byte;
  ssd_kind_type          kind;
  ssd_kind_type          rd_kind;
  logic [2:0]            cfg_idx;
  logic [1:0]            tally_idx;
  logic                  write_ok;
  logic                  guarded;
  logic                  ev_accept;
  logic                  ev_refuse;
  logic                  ev_lock;
  logic                  diag_q;
  logic                  lock_q;
  logic [7:0]            last_cmd_q;
  logic [`SSD_IRQ_W-1:0] irq_stat_q;
  logic [`SSD_IRQ_W-1:0] irq_mask_q;
  logic [`SSD_IRQ_W-1:0] irq_set;
  logic [3:0]            tally_q [3];
  logic [2:0]            tally_ev;
  logic [7:0]            cfg_q [6];
  logic [47:0]           cfg_flat;
  logic                  ack_q;
  logic [31:0]           dat_q;
  logic                  bus_req;
  logic                  bus_wr;

  ssd_spi_link u_link (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .sclk_i        (spi_sclk_i),
    .cs_n_i        (spi_cs_n_i),
    .mosi_i        (spi_mosi_i),
    .miso_o        (spi_miso_o),
    .miso_oe_o     (spi_miso_oe_o),
    .status_i      (status_byte),
    .resp_i        (resp),
    .cmd_valid_o   (cmd_valid),
    .frame_valid_o (frame_valid),
    .abort_o       (frame_abort),
    .word_o        (word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command decode: at frame end the command sits in the upper byte
  assign kind      = ssd_classify(word[15:8]);
  assign cfg_idx   = ssd_cfg_index(word[15:8]);
  assign tally_idx = ssd_tally_index(word[15:8]);
  assign write_ok  = diag_q & ~lock_q;
  assign guarded   = kind == SSD_K_WD_WR || kind == SSD_K_PIN_WR
                  || kind == SSD_K_DEV_WR || kind == SSD_K_CFG_WR;
  assign ev_accept = frame_valid & guarded & write_ok;
  assign ev_refuse = frame_valid & guarded & ~write_ok;
  assign ev_lock   = frame_valid
                  & (kind == SSD_K_LOCK_SET || kind == SSD_K_LOCK_CLR);

  // answer byte is picked when only the command byte has arrived
  assign rd_kind     = ssd_classify(word[7:0]);
  assign status_byte = {lock_q, diag_q, 6'h00};

  always_comb begin
    resp = 8'h00;
    case (rd_kind)
      SSD_K_STAT_RD: resp = {4'h0, tally_q[ssd_tally_index(word[7:0])]};
      SSD_K_CFG_RD:  resp = cfg_q[ssd_cfg_index(word[7:0])];
      default:       resp = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration lock, moved only by its own two commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= `SSD_RST_LOCK;
    end else if (frame_valid && kind == SSD_K_LOCK_SET) begin
      lock_q <= 1'h1;
    end else if (frame_valid && kind == SSD_K_LOCK_CLR) begin
      lock_q <= 1'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_cmd_q <= 8'h00;
    end else if (frame_valid) begin
      last_cmd_q <= word[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // failure tallies: monitors count up and saturate, an accepted serial write overrides
  assign tally_ev = {dev_err_event_i, pin_fail_event_i, wd_fail_event_i};

  generate
    for (genvar g = 0; g < 3; g++) begin : g_tally
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tally_q[g] <= `SSD_RST_TALLY;
        end else if (ev_accept && kind != SSD_K_CFG_WR && tally_idx == 2'(g)) begin
          tally_q[g] <= word[3:0];
        end else if (tally_ev[g] && tally_q[g] != `SSD_TALLY_MAX) begin
          tally_q[g] <= tally_q[g] + 4'h1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // safety limits, threshold and check value
  generate
    for (genvar g = 0; g < 6; g++) begin : g_cfg
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cfg_q[g] <= `SSD_RST_CFG;
        end else if (ev_accept && kind == SSD_K_CFG_WR && cfg_idx == 3'(g)) begin
          cfg_q[g] <= word[7:0];
        end
      end
      assign cfg_flat[g*8 +: 8] = cfg_q[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  // a write lands at the edge that sees ack, while the master still holds it
  assign bus_wr  = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'h0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (bus_req) begin
      case (wb_adr_i)
        `SSD_ADR_CTRL:     dat_q <= {31'h0, diag_q};
        `SSD_ADR_STAT:     dat_q <= {16'h0, last_cmd_q, 7'h0, lock_q};
        `SSD_ADR_IRQ_STAT: dat_q <= {28'h0, irq_stat_q};
        `SSD_ADR_IRQ_MASK: dat_q <= {28'h0, irq_mask_q};
        `SSD_ADR_TALLY:    dat_q <= {20'h0, tally_q[2], tally_q[1], tally_q[0]};
        `SSD_ADR_LIMITS:   dat_q <= cfg_flat[31:0];
        `SSD_ADR_CHECK:    dat_q <= {16'h0, cfg_flat[47:32]};
        default:           dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // self-check state is owned by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      diag_q <= `SSD_RST_DIAG;
    end else if (bus_wr && wb_adr_i == `SSD_ADR_CTRL) begin
      diag_q <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= '0;
    end else if (bus_wr && wb_adr_i == `SSD_ADR_IRQ_MASK) begin
      irq_mask_q <= wb_dat_i[`SSD_IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events; a new event wins over a clear in the same cycle
  always_comb begin
    irq_set                  = '0;
    irq_set[`SSD_IRQ_ACCEPT] = ev_accept;
    irq_set[`SSD_IRQ_REFUSE] = ev_refuse;
    irq_set[`SSD_IRQ_LOCK]   = ev_lock;
    irq_set[`SSD_IRQ_ABORT]  = frame_abort;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else if (bus_wr && wb_adr_i == `SSD_ADR_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~wb_dat_i[`SSD_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cfg_write;
    frame_valid && kind == SSD_K_CFG_WR;
  endsequence

  sequence s_read_cmd;
    frame_valid && (kind == SSD_K_CFG_RD || kind == SSD_K_STAT_RD);
  endsequence

  a_lock_blocks_cfg: assert property (s_cfg_write ##0 lock_q |=> $stable(cfg_flat))
    else $error("configuration changed while locked");
  a_diag_gates_cfg: assert property (s_cfg_write ##0 !diag_q |=> $stable(cfg_flat))
    else $error("configuration changed outside self-check");
  a_cfg_write_lands: assert property (s_cfg_write ##0 write_ok |=>
    cfg_flat[$past(cfg_idx)*8 +: 8] == $past(word[7:0]))
    else $error("accepted configuration write did not land");
  a_wd_tally_write: assert property (
    frame_valid && kind == SSD_K_WD_WR && write_ok |=> tally_q[0] == $past(word[3:0]))
    else $error("watchdog tally write lost");
  a_pin_tally_write: assert property (
    frame_valid && kind == SSD_K_PIN_WR && write_ok |=> tally_q[1] == $past(word[3:0]))
    else $error("error-pin tally write lost");
  a_dev_tally_hold: assert property (
    frame_valid && kind == SSD_K_DEV_WR && !write_ok && !dev_err_event_i
    |=> $stable(tally_q[2]))
    else $error("device tally changed by refused write");
  a_read_no_change: assert property (s_read_cmd |=> $stable(cfg_flat) && $stable(lock_q))
    else $error("read command changed state");
  a_lock_set_cmd: assert property (frame_valid && kind == SSD_K_LOCK_SET |=> lock_q)
    else $error("lock set command ignored");
  a_refuse_flag: assert property (ev_refuse |=> irq_stat_q[`SSD_IRQ_REFUSE][*2])
    else $error("refused write not flagged");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held too long");

  a_ack_follows_req: assert property (bus_req |=> wb_ack_o)
    else $error("request not acknowledged");

  a_ctrl_write_lands: assert property (
    bus_wr && wb_adr_i == `SSD_ADR_CTRL |=> diag_q == $past(wb_dat_i[0]))
    else $error("control write lost");

  a_lock_clear_cmd: assert property (frame_valid && kind == SSD_K_LOCK_CLR |=> !lock_q)
    else $error("lock clear command ignored");

  a_lock_moves_only: assert property (!ev_lock |=> $stable(lock_q))
    else $error("lock moved without its command");

  a_lock_cmd_flag: assert property (ev_lock |=> irq_stat_q[`SSD_IRQ_LOCK])
    else $error("lock command not flagged");

  a_abort_flag: assert property (frame_abort |=> irq_stat_q[`SSD_IRQ_ABORT])
    else $error("aborted frame not flagged");

  // per-slot landing of accepted configuration writes to slots 0..4, then tally write and hold checks
  sequence s_cfg_accept;
    s_cfg_write ##0 write_ok;
  endsequence

  a_high_max_write: assert property (s_cfg_accept ##0 cfg_idx == 3'h0 |=>
    cfg_q[0] == $past(word[7:0]))
    else $error("high maximum write lost");

  a_high_min_write: assert property (s_cfg_accept ##0 cfg_idx == 3'h1 |=>
    cfg_q[1] == $past(word[7:0]))
    else $error("high minimum write lost");

  a_low_max_write: assert property (s_cfg_accept ##0 cfg_idx == 3'h2 |=>
    cfg_q[2] == $past(word[7:0]))
    else $error("low maximum write lost");

  a_low_min_write: assert property (s_cfg_accept ##0 cfg_idx == 3'h3 |=>
    cfg_q[3] == $past(word[7:0]))
    else $error("low minimum write lost");

  a_threshold_write: assert property (s_cfg_accept ##0 cfg_idx == 3'h4 |=>
    cfg_q[4] == $past(word[7:0]))
    else $error("threshold write lost");

  a_wd_tally_hold: assert property (
    frame_valid && kind == SSD_K_WD_WR && !write_ok && !wd_fail_event_i
    |=> $stable(tally_q[0]))
    else $error("watchdog tally changed by refused write");

  a_pin_tally_hold: assert property (
    frame_valid && kind == SSD_K_PIN_WR && !write_ok && !pin_fail_event_i
    |=> $stable(tally_q[1]))
    else $error("error-pin tally changed by refused write");

  a_dev_tally_write: assert property (
    frame_valid && kind == SSD_K_DEV_WR && write_ok |=> tally_q[2] == $past(word[3:0]))
    else $error("device tally write lost");

  a_read_keeps_tally: assert property (s_read_cmd ##0 tally_ev == 3'h0 |=>
    $stable(tally_q[0]) && $stable(tally_q[1]) && $stable(tally_q[2]))
    else $error("read command changed a tally");

endmodule
`default_nettype wire

/* bench/ssd_spi_master.sv */
// link master model: frames command and data bytes onto the serial pins
`default_nettype none
module ssd_spi_master (
  // clock
  input  wire logic clk_i,
  // link pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // mode 0, 400 ns link period; 1 to 15 bits make an aborted frame
  // only listed command codes are ever sent by the bench
  task automatic frame(input logic [15:0] word, input int nbits,
                       output logic [15:0] resp);
    resp = 16'h0000;
    cs_n_o <= 1'b0;
    wait_clk(8);
    for (int i = 15; i > 15 - nbits; i--) begin
      mosi_o <= word[i];
      wait_clk(4);
      sclk_o <= 1'b1;
      resp[i] = miso_i;
      wait_clk(4);
      sclk_o <= 1'b0;
    end
    wait_clk(4);
    cs_n_o <= 1'b1;
    // released data line must not keep showing its last bit
    mosi_o <= ~mosi_o;
    wait_clk(24);
  endtask
endmodule
`default_nettype wire

/* bench/test_ssd_decoder.sv */
// self-checking bench of the safety command decoder
`include "ssd_map.svh"
`default_nettype none
module test_ssd_decoder;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [7:0] wr;
    logic [7:0] rd;
    logic [7:0] val;
    logic [7:0] exp;
  } ssd_row_type;

  localparam ssd_row_type ROWS [9] = '{
    '{`SSD_CMD_HMAX_WR, `SSD_CMD_HMAX_RD, 8'h21, 8'h21},
    '{`SSD_CMD_HMIN_WR, `SSD_CMD_HMIN_RD, 8'h32, 8'h32},
    '{`SSD_CMD_LMAX_WR, `SSD_CMD_LMAX_RD, 8'h43, 8'h43},
    '{`SSD_CMD_LMIN_WR, `SSD_CMD_LMIN_RD, 8'h54, 8'h54},
    '{`SSD_CMD_PWD_WR, `SSD_CMD_PWD_RD, 8'h65, 8'h65},
    '{`SSD_CMD_CHK_WR, `SSD_CMD_CHK_RD, 8'h76, 8'h76},
    '{`SSD_CMD_WD_TALLY_WR, `SSD_CMD_STAT_TWO_RD, 8'hf5, 8'h05},
    '{`SSD_CMD_PIN_TALLY_WR, `SSD_CMD_STAT_THR_RD, 8'h3a, 8'h0a},
    '{`SSD_CMD_DEV_TALLY_WR, `SSD_CMD_STAT_FOUR_RD, 8'h6c, 8'h0c}
  };

  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        spi_sclk_i;
  logic        spi_cs_n_i;
  logic        spi_mosi_i;
  logic        spi_miso_o;
  logic        spi_miso_oe_o;
  logic        wd_i;
  logic        pin_i;
  logic        dev_i;
  logic        irq_o;
  logic [15:0] resp;
  logic [31:0] d;
  int          failures;
  int          checks;

  ssd_decoder ssd_decoder_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i), .spi_mosi_i(spi_mosi_i),
    .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .wd_fail_event_i(wd_i),
    .pin_fail_event_i(pin_i), .dev_err_event_i(dev_i), .irq_o(irq_o)
  );

  ssd_spi_master ssd_spi_master_inst (
    .clk_i(clk_i), .sclk_o(spi_sclk_i), .cs_n_o(spi_cs_n_i),
    .mosi_o(spi_mosi_i), .miso_i(spi_miso_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // entered just after a rising edge; released at the edge that sees ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      failures++;
      results();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] x;
    wb(1'b1, adr, dat, 4'hf, x);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] adr,
                        input logic [31:0] exp);
    logic [31:0] x;
    wb(1'b0, adr, 32'h0, 4'hf, x);
    check(name, x, exp);
  endtask

  task automatic spi(input logic [7:0] cmd, input logic [7:0] dat);
    fork
      ssd_spi_master_inst.frame({cmd, dat}, 16, resp);
      begin
        repeat (20) @(posedge clk_i);
        check("miso enable", spi_miso_oe_o, 1'b1);
      end
    join
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    wd_i = 1'b0;
    pin_i = 1'b0;
    dev_i = 1'b0;
    failures = 0;
    checks = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // every offset, the unmapped 0x1c too, reads zero after reset
    for (int a = 0; a < 32; a += 4)
      rd_chk("reset", 8'(a), 32'h0);
    check("miso idle", spi_miso_oe_o, 1'b0);
    // protected write outside self-check is refused
    spi(`SSD_CMD_HMAX_WR, 8'h5a);
    spi(`SSD_CMD_HMAX_RD, 8'h00);
    check("refused hmax", resp, 16'h0000);
    rd_chk("irq refused", `SSD_ADR_IRQ_STAT, 32'h2);
    wr(`SSD_ADR_IRQ_STAT, 32'hf);
    wr(`SSD_ADR_CTRL, 32'h1);
    foreach (ROWS[i]) begin
      spi(ROWS[i].wr, ROWS[i].val);
      spi(ROWS[i].rd, 8'h00);
      check("read back", resp, {8'h40, ROWS[i].exp});
    end
    rd_chk("tally", `SSD_ADR_TALLY, 32'h0ca5);
    rd_chk("limits", `SSD_ADR_LIMITS, 32'h54433221);
    rd_chk("check", `SSD_ADR_CHECK, 32'h7665);
    rd_chk("irq accept", `SSD_ADR_IRQ_STAT, 32'h1);
    wr(`SSD_ADR_IRQ_STAT, 32'hf);
    // lock blocks config and tally writes even in self-check
    spi(`SSD_CMD_LOCK_SET, 8'h00);
    wb(1'b0, `SSD_ADR_STAT, 32'h0, 4'hf, d);
    check("lock set", d[15:0], 16'h1101);
    spi(`SSD_CMD_PWD_WR, 8'hee);
    spi(`SSD_CMD_PWD_RD, 8'h00);
    check("locked pwd", resp, 16'hc065);
    spi(`SSD_CMD_WD_TALLY_WR, 8'h09);
    spi(`SSD_CMD_STAT_TWO_RD, 8'h00);
    check("locked tally", resp, 16'hc005);
    rd_chk("irq lock", `SSD_ADR_IRQ_STAT, 32'h6);
    check("irq masked", irq_o, 1'b0);
    wr(`SSD_ADR_IRQ_MASK, 32'h2);
    check("irq raised", irq_o, 1'b1);
    wr(`SSD_ADR_IRQ_STAT, 32'h2);
    check("irq cleared", irq_o, 1'b0);
    spi(`SSD_CMD_LOCK_CLR, 8'h00);
    wb(1'b0, `SSD_ADR_STAT, 32'h0, 4'hf, d);
    check("lock clear", d[15:0], 16'h1200);
    // short frame executes nothing
    ssd_spi_master_inst.frame({`SSD_CMD_PWD_WR, 8'h11}, 5, resp);
    rd_chk("abort", `SSD_ADR_CHECK, 32'h7665);
    rd_chk("irq abort", `SSD_ADR_IRQ_STAT, 32'hc);
    // events count up and saturate
    spi(`SSD_CMD_WD_TALLY_WR, 8'h0e);
    wd_i <= 1'b1;
    pin_i <= 1'b1;
    dev_i <= 1'b1;
    @(posedge clk_i);
    pin_i <= 1'b0;
    dev_i <= 1'b0;
    @(posedge clk_i);
    @(posedge clk_i);
    wd_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("events", `SSD_ADR_TALLY, 32'h0dbf);
    // ignored bus writes and tally write outside self-check
    wb(1'b1, `SSD_ADR_CTRL, 32'h0, 4'he, d);
    wr(8'h1c, 32'hffffffff);
    wr(`SSD_ADR_TALLY, 32'h0);
    rd_chk("sel", `SSD_ADR_CTRL, 32'h1);
    rd_chk("unmapped", 8'h1c, 32'h0);
    wr(`SSD_ADR_CTRL, 32'h0);
    spi(`SSD_CMD_DEV_TALLY_WR, 8'h01);
    rd_chk("no diag", `SSD_ADR_TALLY, 32'h0dbf);
    results();
  end
endmodule
`default_nettype wire
